// [dprc_defines.vh]
/*
 * Constants for the dual loop rate configuration block: register
 * addresses, field positions, reset values, loop kind codes and rate units.
 * Assumes it is included by bare name from the design files only.
 */
`ifndef DPRC_DEFINES_VH
`define DPRC_DEFINES_VH

// Register addresses on the serial port.
`define DPRC_ADDR_MODE      3'h0
`define DPRC_ADDR_PRESCALE  3'h1
`define DPRC_ADDR_MULT1     3'h2
`define DPRC_ADDR_MULT2     3'h3
`define DPRC_ADDR_OUTCTL    3'h4
`define DPRC_REG_RESET      5'h00

// Field positions.
`define DPRC_BIT_LOOP_EN    0
`define DPRC_BIT_DIV1       0
`define DPRC_BIT_DIV2       1
`define DPRC_BIT_OE2        2
`define DPRC_BIT_OE1        3
`define DPRC_BIT_OES        4

// Serial frame: bit positions counted from zero, 16 bits per frame.
`define DPRC_SER_DATA_FIRST 5'h08
`define DPRC_SER_LAST       5'h0f
`define DPRC_SER_READ_BITS  5'h05

// Loop output kinds, one-hot.
`define DPRC_KIND_56        3'h1
`define DPRC_KIND_64        3'h2
`define DPRC_KIND_DATA      3'h4

// Rates are in units of 100 Hz.
`define DPRC_RATE_56        16'h0230
`define DPRC_RATE_64        16'h0280
`define DPRC_RATE_DATA0     16'h000c
`define DPRC_RATE_DATA_STEP 16'h0018
`define DPRC_DATA_SAT_CODE  5'h12

// Reference base rates in kHz.
`define DPRC_BASE_T1        16'h0608
`define DPRC_BASE_E1        16'h0800

`endif

// [dprc_loop_rate.v]
/*
 * Rate decode for one synthesis loop: multiplier K from the select
 * code and the resulting output rate for the loop's current kind.
 * Assumes a synchronised active-low reset and a one-hot kind input.
 */
`timescale 1ns/100ps
`include "dprc_defines.vh"

module dprc_loop_rate #(
  parameter CODE_W = 5
) (
  input  wire              clk,
  input  wire              rst_n,
  input  wire [CODE_W-1:0] code,
  input  wire [2:0]        kind,
  input  wire              table_ok,
  output reg  [CODE_W:0]   k_r,
  output reg  [15:0]       rate_r,
  output reg               rate_ok_r
);

  reg [CODE_W:0] k_nxt;     // Multiplier, code plus one.
  reg [15:0]     rate_nxt;  // Output rate in 100 Hz units.
  reg [CODE_W-1:0] sat;     // Data code clipped at the top step.
  wire [15:0]    k_ext;     // Multiplier widened to the rate width.

  // Widened here so the products below keep all sixteen bits.
  assign k_ext = {{(16-CODE_W){1'b0}}, code} + 16'h0001;

  // K is code plus one; the rate follows the loop kind.
  always @* begin
    k_nxt = {1'b0, code} + {{CODE_W{1'b0}}, 1'b1};
    sat = (code > `DPRC_DATA_SAT_CODE) ? `DPRC_DATA_SAT_CODE : code;
    case (kind)
      `DPRC_KIND_56: rate_nxt = k_ext * `DPRC_RATE_56;
      `DPRC_KIND_64: rate_nxt = k_ext * `DPRC_RATE_64;
      `DPRC_KIND_DATA: begin
        // Codes past the top step saturate at 43.2 kHz.
        if (code == {CODE_W{1'b0}}) begin
          rate_nxt = `DPRC_RATE_DATA0;
        end else begin
          rate_nxt = {{(16-CODE_W){1'b0}}, sat}
                     * `DPRC_RATE_DATA_STEP;
        end
      end
      default: rate_nxt = 16'h0000;
    endcase
  end

  // Results are registered so the outputs stay glitch free.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      k_r       <= {(CODE_W+1){1'b0}};
      rate_r    <= 16'h0000;
      rate_ok_r <= 1'b0;
    end else begin
      k_r       <= k_nxt;
      // Outside the table's modes the code sets no rate.
      rate_r    <= table_ok ? rate_nxt : 16'h0000;
      rate_ok_r <= table_ok;
    end
  end

endmodule // dprc_loop_rate

// [dprc_top.v]
/*
 * Dual loop rate configuration: serial command port, the five command
 * registers, mode decode, prescaler ratio, per-loop rate decode,
 * sync-to-clock delay lookup and output drive enables.
 * Assumes csb_b, sclk and sdi are synchronous to clk, and that sclk is
 * much slower than clk so each of its edges is seen once.
 */
`timescale 1ns/100ps
`include "dprc_defines.vh"

module dprc_top (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        master_sel,
  input  wire        csb_b,
  input  wire        sclk,
  input  wire        sdi,
  output reg         sdo_o,
  output reg         sdo_oe,
  output reg         loop1_run,
  output reg         loop2_run,
  output reg  [3:0]  loop_mode_select,
  output reg         prescale_valid,
  output reg  [4:0]  prescale_ratio,
  output reg  [15:0] ref_rate_khz,
  output wire [5:0]  loop1_k,
  output wire [15:0] loop1_rate,
  output wire        loop1_rate_ok,
  output wire [5:0]  loop2_k,
  output wire [15:0] loop2_rate,
  output wire        loop2_rate_ok,
  output reg  [9:0]  sync_delay,
  output reg         sync_delay_ok,
  output reg         loop1_div8,
  output reg         loop2_div8,
  output reg         out1_drive_enable,
  output reg         out2_drive_enable,
  output reg         frame_pulse_drive_enable
);

  // One-hot serial port states.
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_HEAD = 3'b010;
  localparam [2:0] ST_DATA = 3'b100;

  reg        rst_m_r;        // Reset synchroniser, first stage.
  reg        rst_n_r;        // Synchronised reset used everywhere.
  reg [4:0]  mode_r;         // Mode bits and first loop enable.
  reg [4:0]  prescale_r;     // Second loop enable and prescale code.
  reg [4:0]  mult1_r;        // First loop multiplier select.
  reg [4:0]  mult2_r;        // Second loop multiplier select.
  reg [4:0]  outctl_r;       // Dividers and drive enables.
  reg        sclk_r;         // Previous sclk sample for edges.
  reg [2:0]  state_r;        // Serial port state.
  reg [2:0]  state_nxt;
  reg [4:0]  bit_r;          // Bits taken in this frame.
  reg        rd_r;           // Frame is a read.
  reg [2:0]  addr_r;         // Frame address.
  reg [7:0]  wdata_r;        // Write data shifted in LSB first.
  reg [4:0]  rdata_r;        // Read data shifted out LSB first.
  reg [4:0]  rd_mux;         // Addressed register value.
  reg [2:0]  kind1;          // First loop kind from the mode bits.
  reg [2:0]  kind2;          // Second loop kind from the mode bits.
  reg        reverse;        // Mode code selects reverse operation.
  reg [19:0] delay_pair;     // Delay for 56k and 64k multiples.
  wire       rise;
  wire       fall;
  wire [3:0] mcode;

  assign rise  = sclk & ~sclk_r;
  assign fall  = ~sclk & sclk_r;
  assign mcode = mode_r[4:1];

  // Reset is applied at once and released through two flip-flops.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n_r <= rst_m_r;
    end
  end

  // A frame starts when chip select falls and ends when it rises;
  // raising it early abandons the frame without any write.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (!csb_b) state_nxt = ST_HEAD;
      ST_HEAD: begin
        if (csb_b) begin
          state_nxt = ST_IDLE;
        end else if (rise && bit_r == `DPRC_SER_DATA_FIRST - 5'h01) begin
          state_nxt = ST_DATA;
        end
      end
      ST_DATA: if (csb_b) state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Readback of the addressed register; reserved space reads zero.
  always @* begin
    case (addr_r)
      `DPRC_ADDR_MODE:     rd_mux = mode_r;
      `DPRC_ADDR_PRESCALE: rd_mux = prescale_r;
      `DPRC_ADDR_MULT1:    rd_mux = mult1_r;
      `DPRC_ADDR_MULT2:    rd_mux = mult2_r;
      `DPRC_ADDR_OUTCTL:   rd_mux = outctl_r;
      default:             rd_mux = 5'h00;
    endcase
  end

  // Serial shifter: command bits and data on rising sclk, read data
  // launched on falling sclk so the host can take it on the next rise.
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_IDLE;
      sclk_r  <= 1'b0;
      bit_r   <= 5'h00;
      rd_r    <= 1'b0;
      addr_r  <= 3'h0;
      wdata_r <= 8'h00;
      rdata_r <= 5'h00;
      sdo_o   <= 1'b0;
      sdo_oe  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sclk_r  <= sclk;
      if (state_r == ST_IDLE) begin
        bit_r  <= 5'h00;
        sdo_oe <= 1'b0;
        sdo_o  <= 1'b0;
      end else if (csb_b) begin
        // Release the data pin as soon as the frame ends.
        sdo_oe <= 1'b0;
      end else begin
        if (rise && bit_r <= `DPRC_SER_LAST) begin
          bit_r <= bit_r + 5'h01;
          if (bit_r == 5'h00) begin
            rd_r <= sdi;
          end else if (bit_r < 5'h04) begin
            addr_r <= {sdi, addr_r[2:1]};
          end else if (state_r == ST_DATA) begin
            wdata_r <= {sdi, wdata_r[7:1]};
          end
        end
        if (fall && rd_r && bit_r >= `DPRC_SER_DATA_FIRST
            && bit_r <= `DPRC_SER_LAST) begin
          // Data bits D0 to D4 go out first, then zeros.
          if (bit_r == `DPRC_SER_DATA_FIRST) begin
            sdo_oe  <= 1'b1;
            sdo_o   <= rd_mux[0];
            rdata_r <= {1'b0, rd_mux[4:1]};
          end else begin
            sdo_o   <= rdata_r[0];
            rdata_r <= {1'b0, rdata_r[4:1]};
          end
        end
      end
    end
  end

  // Registers load on the sixteenth rising sclk of a write; the upper
  // three data bits are dropped.  All clear to zero at reset.
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_r     <= `DPRC_REG_RESET;
      prescale_r <= `DPRC_REG_RESET;
      mult1_r    <= `DPRC_REG_RESET;
      mult2_r    <= `DPRC_REG_RESET;
      outctl_r   <= `DPRC_REG_RESET;
    end else if (state_r == ST_DATA && !csb_b && rise && !rd_r
                 && bit_r == `DPRC_SER_LAST) begin
      case (addr_r)
        // Seven data bits are in by now, D0 sitting at bit 1.
        `DPRC_ADDR_MODE:     mode_r     <= wdata_r[5:1];
        `DPRC_ADDR_PRESCALE: prescale_r <= wdata_r[5:1];
        `DPRC_ADDR_MULT1:    mult1_r    <= wdata_r[5:1];
        `DPRC_ADDR_MULT2:    mult2_r    <= wdata_r[5:1];
        `DPRC_ADDR_OUTCTL:   outctl_r   <= wdata_r[5:1];
        default:             ;  // Reserved addresses take no write.
      endcase
    end
  end

  // Mode decode: the low three mode bits pick the pair of loop kinds,
  // codes 6 and 7 are reverse and leave the multiplier tables unused.
  always @* begin
    reverse = (mcode[2:1] == 2'b11);
    case (mcode[2:0])
      3'h0: begin kind1 = `DPRC_KIND_56;   kind2 = `DPRC_KIND_56;   end
      3'h1: begin kind1 = `DPRC_KIND_56;   kind2 = `DPRC_KIND_64;   end
      3'h2: begin kind1 = `DPRC_KIND_64;   kind2 = `DPRC_KIND_64;   end
      3'h3: begin kind1 = `DPRC_KIND_56;   kind2 = `DPRC_KIND_DATA; end
      3'h4: begin kind1 = `DPRC_KIND_64;   kind2 = `DPRC_KIND_DATA; end
      3'h5: begin kind1 = `DPRC_KIND_DATA; kind2 = `DPRC_KIND_DATA; end
      default: begin kind1 = 3'h0; kind2 = 3'h0; end
    endcase
  end

  // Sync-to-clock delay against the first loop code, in 56k and 64k
  // multiple columns.
  always @* begin
    case (mult1_r)
      5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h0b, 5'h17:
               delay_pair = {10'h174, 10'h146};
      5'h04, 5'h13: delay_pair = {10'h1be, 10'h187};
      5'h06, 5'h0d, 5'h1b: delay_pair = {10'h13f, 10'h117};
      5'h07, 5'h0f, 5'h1f: delay_pair = {10'h117, 10'h0f4};
      5'h08, 5'h11: delay_pair = {10'h1f0, 10'h1b2};
      5'h09:   delay_pair = {10'h1be, 10'h12d};
      5'h0a, 5'h15: delay_pair = {10'h196, 10'h163};
      5'h0c, 5'h19: delay_pair = {10'h157, 10'h12d};
      5'h0e, 5'h1d: delay_pair = {10'h12a, 10'h104};
      5'h10:   delay_pair = {10'h20d, 10'h1cc};
      5'h12:   delay_pair = {10'h1d6, 10'h19b};
      5'h14:   delay_pair = {10'h1a9, 10'h174};
      5'h16:   delay_pair = {10'h184, 10'h154};
      5'h18:   delay_pair = {10'h165, 10'h138};
      5'h1a:   delay_pair = {10'h14b, 10'h121};
      5'h1c:   delay_pair = {10'h134, 10'h117};
      5'h1e:   delay_pair = {10'h120, 10'h0fc};
      default: delay_pair = 20'h00000;
    endcase
  end

  // Configuration outputs, all registered.
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      loop1_run                <= 1'b0;
      loop2_run                <= 1'b0;
      loop_mode_select         <= 4'h0;
      prescale_valid           <= 1'b0;
      prescale_ratio           <= 5'h00;
      ref_rate_khz             <= 16'h0000;
      sync_delay               <= 10'h000;
      sync_delay_ok            <= 1'b0;
      loop1_div8               <= 1'b0;
      loop2_div8               <= 1'b0;
      out1_drive_enable        <= 1'b0;
      out2_drive_enable        <= 1'b0;
      frame_pulse_drive_enable <= 1'b0;
    end else begin
      loop1_run        <= mode_r[`DPRC_BIT_LOOP_EN];
      loop2_run        <= prescale_r[`DPRC_BIT_LOOP_EN];
      loop_mode_select <= mcode;
      // The prescaler only acts in master forward; in reverse its
      // code is ignored, and slave inputs are already 8 kHz.
      prescale_valid <= master_sel & ~reverse;
      if (master_sel && !reverse) begin
        prescale_ratio <= {1'b0, prescale_r[4:1]} + 5'h01;
        ref_rate_khz   <= {11'h000, ({1'b0, prescale_r[4:1]} + 5'h01)}
                          * (mcode[3] ? `DPRC_BASE_E1 : `DPRC_BASE_T1);
      end else begin
        prescale_ratio <= 5'h00;
        ref_rate_khz   <= 16'h0000;
      end
      // The delay holds only for 56k or 64k multiples, not in reverse,
      // and not for 56k multiples with the divide by 8 on.
      if (!reverse && (kind1 == `DPRC_KIND_64 || (kind1 == `DPRC_KIND_56
          && !outctl_r[`DPRC_BIT_DIV1]))) begin
        sync_delay_ok <= 1'b1;
        sync_delay    <= (kind1 == `DPRC_KIND_56) ? delay_pair[19:10]
                                                  : delay_pair[9:0];
      end else begin
        sync_delay_ok <= 1'b0;
        sync_delay    <= 10'h000;
      end
      loop1_div8               <= outctl_r[`DPRC_BIT_DIV1];
      loop2_div8               <= outctl_r[`DPRC_BIT_DIV2];
      out2_drive_enable        <= outctl_r[`DPRC_BIT_OE2];
      out1_drive_enable        <= outctl_r[`DPRC_BIT_OE1];
      frame_pulse_drive_enable <= outctl_r[`DPRC_BIT_OES];
    end
  end

  // First loop rate; tables apply in forward modes, master or slave.
  dprc_loop_rate #(.CODE_W(5)) u_loop1 (
    .clk       (clk),
    .rst_n     (rst_n_r),
    .code      (mult1_r),
    .kind      (kind1),
    .table_ok  (~reverse),
    .k_r       (loop1_k),
    .rate_r    (loop1_rate),
    .rate_ok_r (loop1_rate_ok)
  );

  // Second loop uses its own code, independent of the first.
  dprc_loop_rate #(.CODE_W(5)) u_loop2 (
    .clk       (clk),
    .rst_n     (rst_n_r),
    .code      (mult2_r),
    .kind      (kind2),
    .table_ok  (~reverse),
    .k_r       (loop2_k),
    .rate_r    (loop2_rate),
    .rate_ok_r (loop2_rate_ok)
  );

endmodule // dprc_top

// [dprc_top_asserts.sv]
/*
 * Checker for the rate configuration block: ties the decoded rates
 * and gates to the register-facing outputs, and the serial output enable to chip select.
 * Assumes it is bound to dprc_top and sees only that module's ports.
 */
`timescale 1ns/100ps
module dprc_top_asserts (
  input wire        clk,
  input wire        rst_b,
  input wire        master_sel,
  input wire        csb_b,
  input wire        sdo_oe,
  input wire [3:0]  loop_mode_select,
  input wire        prescale_valid,
  input wire [4:0]  prescale_ratio,
  input wire [15:0] ref_rate_khz,
  input wire [5:0]  loop1_k,
  input wire [15:0] loop1_rate,
  input wire        loop1_rate_ok,
  input wire [5:0]  loop2_k,
  input wire [15:0] loop2_rate,
  input wire        loop2_rate_ok,
  input wire [9:0]  sync_delay,
  input wire        sync_delay_ok,
  input wire        loop1_div8
);
  reg  [2:0] quiet_r; // Idle cycles since the last frame or strap change.
  reg        strap_r; // Master strap seen one cycle ago.
  wire       rev;     // Reverse modes: low mode bits 110 or 111.
  wire       quiet;   // Registered outputs have settled.
  assign rev   = loop_mode_select[2:1] == 2'h3;
  assign quiet = quiet_r >= 3'h6 && csb_b && strap_r == master_sel;

  // Outputs lag their cause by a few edges, so only settled values are
  // compared; a frame or strap change restarts the count.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      quiet_r <= 3'h0;
      strap_r <= 1'b0;
    end else begin
      strap_r <= master_sel;
      if (!csb_b || strap_r != master_sel)
        quiet_r <= 3'h0;
      else if (quiet_r != 3'h7)
        quiet_r <= quiet_r + 3'h1;
    end
  end

  // Output kind of a loop: 0 is 56k, 1 is 64k, 2 is data, 3 is none.
  function [1:0] kind(input [2:0] m, input lp2);
    case (m)
      3'h0:    kind = 2'h0;
      3'h1:    kind = lp2 ? 2'h1 : 2'h0;
      3'h2:    kind = 2'h1;
      3'h3:    kind = lp2 ? 2'h2 : 2'h0;
      3'h4:    kind = lp2 ? 2'h2 : 2'h1;
      3'h5:    kind = 2'h2;
      default: kind = 2'h3;
    endcase
  endfunction

  // Rate in 100 Hz units from kind and multiplier.
  function [15:0] rate(input [1:0] kd, input [5:0] k);
    case (kd)
      2'h0:    rate = k * 16'h0230;
      2'h1:    rate = k * 16'h0280;
      2'h2:    rate = (k == 6'h01) ? 16'h000c :
                 ((k > 6'h13) ? 6'h12 : k - 6'h01) * 16'h0018;
      default: rate = 16'h0000;
    endcase
  endfunction

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_ref_rate_scale: assert property (
    quiet && prescale_valid |-> ref_rate_khz == prescale_ratio *
      (loop_mode_select[3] ? 16'h0800 : 16'h0608))
    else $error("reference rate does not match the prescale ratio");
  a_prescale_gate: assert property (
    quiet |-> prescale_valid == (master_sel && !rev) &&
      (prescale_valid ? prescale_ratio != 5'h00 :
       prescale_ratio == 5'h00 && ref_rate_khz == 16'h0000))
    else $error("prescale gating wrong for strap and mode");
  a_loop1_rate: assert property (
    quiet |-> loop1_rate == rate(kind(loop_mode_select[2:0], 1'b0), loop1_k))
    else $error("first loop rate wrong");
  a_loop2_rate: assert property (
    quiet |-> loop2_rate == rate(kind(loop_mode_select[2:0], 1'b1), loop2_k))
    else $error("second loop rate wrong");
  a_rate_ok_rev: assert property (
    quiet |-> loop1_rate_ok == !rev && loop2_rate_ok == !rev)
    else $error("rate valid flags wrong for mode");
  a_delay_gate: assert property (
    quiet |-> sync_delay_ok == (!rev && (kind(loop_mode_select[2:0], 1'b0)
      == 2'h1 || kind(loop_mode_select[2:0], 1'b0) == 2'h0 && !loop1_div8))
      && (sync_delay_ok || sync_delay == 10'h000))
    else $error("delay valid flag wrong");
  a_delay_value: assert property (
    quiet && sync_delay_ok && loop1_k inside {6'h01, 6'h02, 6'h03, 6'h04,
      6'h06, 6'h0c, 6'h18} |-> sync_delay ==
      (kind(loop_mode_select[2:0], 1'b0) == 2'h1 ? 10'h146 : 10'h174))
    else $error("sync delay wrong for multiplier");
  a_regs_hold: assert property (
    quiet |=> $stable({loop_mode_select, loop1_k, loop2_k, loop1_div8}))
    else $error("settings changed without a frame");
  a_sdo_idle: assert property (
    csb_b [*2] |-> !sdo_oe)
    else $error("serial output driven while deselected");
endmodule // dprc_top_asserts

bind dprc_top dprc_top_asserts u_chk (
  .clk(clk), .rst_b(rst_b), .master_sel(master_sel), .csb_b(csb_b),
  .sdo_oe(sdo_oe), .loop_mode_select(loop_mode_select),
  .prescale_valid(prescale_valid), .prescale_ratio(prescale_ratio),
  .ref_rate_khz(ref_rate_khz), .loop1_k(loop1_k), .loop1_rate(loop1_rate),
  .loop1_rate_ok(loop1_rate_ok), .loop2_k(loop2_k), .loop2_rate(loop2_rate),
  .loop2_rate_ok(loop2_rate_ok), .sync_delay(sync_delay),
  .sync_delay_ok(sync_delay_ok), .loop1_div8(loop1_div8));

// [dprc_host_model.sv]
/*
 * Host side of the four-wire serial port: runs whole or cut-short
 * frames and collects read data.
 * Assumes clk is the block clock; each serial phase lasts 4 clk cycles.
 */
`timescale 1ns/100ps
module dprc_host_model (
  input  wire clk,
  input  wire sdo_o,
  input  wire sdo_oe,
  output reg  csb_b,
  output reg  sclk,
  output reg  sdi
);
  // Deselected, serial clock parked low between frames.
  initial begin
    csb_b = 1'b1;
    sclk  = 1'b0;
    sdi   = 1'b0;
  end

  // Frame bits: R/W, A0..A2, four low bits, D0..D7, LSB first. Fewer
  // than 16 rises leaves the frame abandoned.
  task xfer(input rw, input [2:0] a, input [7:0] d, input [4:0] n,
            output [4:0] q);
    reg [15:0] f;
    integer    i;
    begin
      f = {d, 4'h0, a, rw};
      q = 5'h00;
      @(posedge clk);
      #1 csb_b = 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        sclk = 1'b0;
        sdi  = f[i];
        repeat (4) @(posedge clk);
        #1 sclk = 1'b1;
        repeat (4) @(posedge clk);
        // A released line has no pull, so it shows the inverse.
        if (i >= 8 && i < 13)
          q[i-8] = sdo_oe ? sdo_o : ~sdo_o;
        #1;
      end
      sclk = 1'b0;
      repeat (4) @(posedge clk);
      #1 csb_b = 1'b1;
      sdi = ~sdi;
      // Deselect time of at least 250 ns before the next frame.
      repeat (13) @(posedge clk);
      #1;
    end
  endtask
endmodule // dprc_host_model

// [test_dual_pll_rate_config.sv]
/*
 * Self-checking bench: random settings with corner multiplier codes,
 * read-back, reserved addresses and abandoned frames.
 * Assumes the checker is bound and the host model drives the port.
 */
`timescale 1ns/100ps
module test_dual_pll_rate_config;
  reg         clk, rst_b, master_sel, rv, pv, dk;
  wire        csb_b, sclk, sdi, sdo_o, sdo_oe, loop1_run, loop2_run;
  wire        prescale_valid, loop1_rate_ok, loop2_rate_ok, sync_delay_ok;
  wire        loop1_div8, loop2_div8, out1_drive_enable, out2_drive_enable;
  wire        frame_pulse_drive_enable;
  wire [3:0]  loop_mode_select;
  wire [4:0]  prescale_ratio;
  wire [5:0]  loop1_k, loop2_k;
  wire [9:0]  sync_delay;
  wire [15:0] ref_rate_khz, loop1_rate, loop2_rate;
  reg  [4:0]  md, ps, c1, c2, oc, q;  // Settings written and data read.
  reg  [2:0]  hi, ra;                 // Ignored data bits, reserved address.
  integer     err_total, n_tests, seed, i;

  dprc_top DUT (.clk(clk), .rst_b(rst_b), .master_sel(master_sel),
    .csb_b(csb_b), .sclk(sclk), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .loop1_run(loop1_run), .loop2_run(loop2_run),
    .loop_mode_select(loop_mode_select), .prescale_valid(prescale_valid),
    .prescale_ratio(prescale_ratio), .ref_rate_khz(ref_rate_khz),
    .loop1_k(loop1_k), .loop1_rate(loop1_rate),
    .loop1_rate_ok(loop1_rate_ok), .loop2_k(loop2_k),
    .loop2_rate(loop2_rate), .loop2_rate_ok(loop2_rate_ok),
    .sync_delay(sync_delay), .sync_delay_ok(sync_delay_ok),
    .loop1_div8(loop1_div8), .loop2_div8(loop2_div8),
    .out1_drive_enable(out1_drive_enable),
    .out2_drive_enable(out2_drive_enable),
    .frame_pulse_drive_enable(frame_pulse_drive_enable));
  dprc_host_model u_host (.clk(clk), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .csb_b(csb_b), .sclk(sclk), .sdi(sdi));

  // Free-running 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Output kind of a loop: 0 is 56k, 1 is 64k, 2 is data, 3 is none.
  function [1:0] f_kind(input [2:0] m, input lp2);
    case (m)
      3'h0:    f_kind = 2'h0;
      3'h1:    f_kind = lp2 ? 2'h1 : 2'h0;
      3'h2:    f_kind = 2'h1;
      3'h3:    f_kind = lp2 ? 2'h2 : 2'h0;
      3'h4:    f_kind = lp2 ? 2'h2 : 2'h1;
      3'h5:    f_kind = 2'h2;
      default: f_kind = 2'h3;
    endcase
  endfunction

  // Expected rate in 100 Hz units; data codes above 18 saturate.
  function [15:0] f_rate(input [1:0] kd, input [4:0] c);
    case (kd)
      2'h0:    f_rate = ({11'h000, c} + 16'h0001) * 16'h0230;
      2'h1:    f_rate = ({11'h000, c} + 16'h0001) * 16'h0280;
      2'h2:    f_rate = (c == 5'h00) ? 16'h000c :
                 ((c > 5'h12) ? 16'h0012 : {11'h000, c}) * 16'h0018;
      default: f_rate = 16'h0000;
    endcase
  endfunction

  // Counts every comparison and reports each mismatch.
  task chk(input [8*12:1] nm, input [15:0] seen, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("Error %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  task wr(input [2:0] a, input [7:0] d);
    u_host.xfer(1'b0, a, d, 5'h10, q);
  endtask

  task rd(input [2:0] a);
    u_host.xfer(1'b1, a, 8'h00, 5'h10, q);
  endtask

  task print_verdict;
    begin
      if (err_total == 0 && n_tests > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  // Cuts a hang short well after the expected 35k cycles.
  initial begin
    #(20 * 60000);
    err_total = err_total + 1;
    print_verdict;
  end

  // Main sequence: reset values, then random and corner settings.
  initial begin
    seed = 35;
    err_total = 0;
    n_tests = 0;
    rst_b = 1'b0;
    master_sel = 1'b0;
    repeat (12) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    for (i = 0; i < 8; i = i + 1) begin
      rd(i);
      chk("reset_read", q, 16'h0000);
    end
    for (i = 0; i < 24; i = i + 1) begin
      {md, ps, c1, c2} = $random(seed);
      {oc, hi} = $random(seed);
      master_sel = $random(seed);
      // First passes hit data-mode edges of the multiplier codes.
      if (i < 4) begin
        md[3:1] = 3'h5;
        c1 = (i == 0) ? 5'h00 : (i == 1) ? 5'h11 : (i == 2) ? 5'h12 : 5'h1f;
        c2 = ~c1;
      end else if (i < 8) begin
        // Delay corners in both multiple modes, divide by 8 off.
        md[3:1] = i[1] ? 3'h0 : 3'h2;
        c1 = i[0] ? 5'h10 : 5'h17;
        oc[0] = 1'b0;
      end
      wr(3'h0, {hi, md});
      wr(3'h1, {hi, ps});
      wr(3'h2, {hi, c1});
      wr(3'h3, {hi, c2});
      wr(3'h4, {hi, oc});
      // A cut-short frame and a reserved write must change nothing.
      u_host.xfer(1'b0, 3'h4, {hi, ~oc}, 5'h0c, q);
      ra = (i % 3) + 5;
      wr(ra, {hi, oc});
      rd(ra);
      chk("reserved", q, 16'h0000);
      rd(3'h4);
      chk("outctl_read", q, oc);
      rd(3'h2);
      chk("mult1_read", q, c1);
      rv = md[3] & md[2];
      pv = master_sel & ~rv;
      chk("loop2_run", loop2_run, ps[0]);
      chk("ratio", prescale_ratio, pv ? ps[4:1] + 5'h01 : 5'h00);
      chk("ref_rate", ref_rate_khz, pv ? (ps[4:1] + 16'h0001) *
        (md[4] ? 16'h0800 : 16'h0608) : 16'h0000);
      chk("loop1_k", loop1_k, c1 + 6'h01);
      chk("loop2_k", loop2_k, c2 + 6'h01);
      chk("loop1_rate", loop1_rate,
        f_rate(f_kind(md[3:1], 1'b0), c1));
      chk("loop2_rate", loop2_rate,
        f_rate(f_kind(md[3:1], 1'b1), c2));
      chk("rate_ok", {loop1_rate_ok, loop2_rate_ok}, {2{~rv}});
      dk = ~rv & (f_kind(md[3:1], 1'b0) == 2'h1 |
        f_kind(md[3:1], 1'b0) == 2'h0 & ~oc[0]);
      chk("delay_ok", sync_delay_ok, dk);
      if (!dk)
        chk("sync_delay", sync_delay, 16'h0000);
      else if (c1 == 5'h00 || c1 == 5'h05 || c1 == 5'h17)
        chk("sync_delay", sync_delay, f_kind(md[3:1], 1'b0) == 2'h1 ?
          16'h0146 : 16'h0174);
      else if (c1 == 5'h10)
        chk("sync_delay", sync_delay, f_kind(md[3:1], 1'b0) == 2'h1 ?
          16'h01cc : 16'h020d);
      chk("loop1_run", loop1_run, md[0]);
      chk("mode_select", loop_mode_select, md[4:1]);
      chk("presc_valid", prescale_valid, pv);
      chk("div8_1", loop1_div8, oc[0]);
      chk("div8_2", loop2_div8, oc[1]);
      chk("drive2", out2_drive_enable, oc[2]);
      chk("drive1", out1_drive_enable, oc[3]);
      chk("drive_sync", frame_pulse_drive_enable, oc[4]);
    end
    print_verdict;
  end
endmodule // test_dual_pll_rate_config
